// [common/rscd_consts.svh]
// constants of the serial command decoder
`ifndef RSCD_CONSTS_SVH
`define RSCD_CONSTS_SVH
`define RSCD_CMD_RD_REG      3'h0
`define RSCD_CMD_WR_REG      3'h1
`define RSCD_CMD_RX_READ     8'h61
`define RSCD_CMD_TX_WRITE    8'hA0
`define RSCD_CMD_FLUSH_TX    8'hE1
`define RSCD_CMD_FLUSH_RX    8'hE2
`define RSCD_CMD_REPEAT      8'hE3
`define RSCD_CMD_ACTIVATE    8'h50
`define RSCD_CMD_WIDTH_RD    8'h60
`define RSCD_CMD_ACK_WRITE   5'h15
`define RSCD_CMD_UNACKED     8'hB0
`define RSCD_CMD_NOP         8'hFF
`define RSCD_ACT_FEATURES    8'h73
`define RSCD_ACT_BANK        8'h53
`define RSCD_PIPE_MAX        3'h5
`define RSCD_BANK1_MSB_LAST  5'h08
`define RSCD_BANK_REG        5'h07
`define RSCD_BANK_BIT        7
`define RSCD_PAYLOAD_MAX     32
`define RSCD_REG_MAX         5
`define RSCD_IDX_W           6
`endif

// [common/rscd_pkg.sv]
// types of the serial command decoder
package rscd_pkg;
    typedef enum logic [3:0] {
        RSCD_IDLE = 4'h1,
        RSCD_CMD  = 4'h2,
        RSCD_DATA = 4'h4,
        RSCD_DEAD = 4'h8
    } rscd_phase_t;

    typedef struct packed {
        logic        sck_s1, sck_s2, sck_s3;
        logic        mosi_s1, mosi_s2;
        logic        cs_s1, cs_s2, cs_s3;
        rscd_phase_t phase;
        logic [7:0]  shift_in;
        logic [7:0]  shift_out;
        logic [2:0]  bit_cnt;
        logic [5:0]  byte_cnt;
        logic [7:0]  cmd;
        logic [7:0]  next_byte;
        logic        pend;
        logic        fetch;
        logic        wrote;
        logic        read_rx;
        logic        miso;
        logic        miso_oe;
        logic [4:0]  reg_addr;
        logic [2:0]  reg_byte_sel;
        logic        reg_rd_req;
        logic        reg_wr_en;
        logic [7:0]  wr_data;
        logic [5:0]  data_idx;
        logic        tx_wr_en;
        logic        tx_wr_noack;
        logic        tx_wr_ack;
        logic [2:0]  tx_wr_pipe;
        logic        tx_commit;
        logic        rx_rd_req;
        logic        rx_pop;
        logic        flush_tx;
        logic        flush_rx;
        logic        tx_reuse;
        logic        features_on;
        logic        bank;
    } rscd_state_t;
endpackage

// [rtl/rscd_top.sv]
// serial command decoder of the packet transceiver
`timescale 1ns/1ps
`include "rscd_consts.svh"

// Function
// - a chip select falling edge starts a frame; first byte is a command
// - status register shifts out while the command byte shifts in
// - command is one byte, most significant bit first
// - bank 0 and bank 1 regs 9-14: least significant byte first
// - bank 1 regs 0-8: most significant byte first, bits msb first
// - register read 000+address returns 1 to 5 register bytes
// - register write 001+address, 1-5 bytes, only in power-down/standby
// - receive payload read returns bytes from 0, then pops the entry
// - transmit payload write stores 1-32 bytes from byte 0
// - transmit flush empties the transmit queue, no data bytes
// - repeat command makes transmitter resend last payload while enabled
// - activate with 0x73 toggles three feature commands; power-down/standby only
// - inactive feature commands ignore writes and read zeros
// - activate with 0x53 toggles bank; bank shows in reg 7 bit 7
// - width read returns length of the top receive entry
// - ack payload write: pipe 0-5, receiver only, max three pending
// - unacked payload write loads a packet sent without acknowledge
// - no-operation only shifts the status byte out
// - repeat flag set by repeat, cleared by transmit payload write or transmit flush
// - each queue holds three entries of up to 32 bytes
module rscd_top
    import rscd_pkg::*;
#(
    parameter int PAYLOAD_MAX = `RSCD_PAYLOAD_MAX,
    parameter int REG_MAX     = `RSCD_REG_MAX
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // serial pins from the host
    input  wire logic       chip_select_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    // device state
    input  wire logic [7:0] status_in,
    input  wire logic       write_ok,
    input  wire logic       prim_rx,
    input  wire logic       ack_queue_full,
    // register file
    output logic [4:0]      reg_addr,
    output logic [2:0]      reg_byte_sel,
    input  wire logic [2:0] reg_width,
    output logic            reg_rd_req,
    input  wire logic [7:0] reg_rd_data,
    output logic            reg_wr_en,
    output logic [7:0]      wr_data,
    // payload queues
    output logic [5:0]      data_idx,
    output logic            tx_wr_en,
    output logic            tx_wr_noack,
    output logic            tx_wr_ack,
    output logic [2:0]      tx_wr_pipe,
    output logic            tx_commit,
    output logic            rx_rd_req,
    input  wire logic [7:0] rx_rd_data,
    input  wire logic [7:0] rx_top_width,
    output logic            rx_pop,
    output logic            flush_tx,
    output logic            flush_rx,
    // mode outputs
    output logic            tx_reuse,
    output logic            features_on,
    output logic            bank
);
    import rscd_pkg::*;

    if (PAYLOAD_MAX < 1 || PAYLOAD_MAX > `RSCD_PAYLOAD_MAX ||
        REG_MAX < 1 || REG_MAX > 7) begin : g_bad
        $error("rscd_top: unsupported PAYLOAD_MAX or REG_MAX");
    end

    rscd_state_t st;
    rscd_state_t next_st;

    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;
    logic       cs_rise;
    logic       byte_done;
    logic [7:0] rx_byte;
    logic [7:0] fetch_src;

    // bank 1 low registers go out most significant byte first
    function automatic logic [2:0] byte_sel(input logic [4:0] addr,
            input logic [5:0] idx, input logic [2:0] width,
            input logic bk);
        if (bk && addr <= `RSCD_BANK1_MSB_LAST)
            byte_sel = 3'(width - 3'h1 - idx[2:0]);
        else
            byte_sel = idx[2:0];
    endfunction

    function automatic logic is_payload_write(input logic [7:0] c);
        is_payload_write = c == `RSCD_CMD_TX_WRITE ||
            c == `RSCD_CMD_UNACKED || c[7:3] == `RSCD_CMD_ACK_WRITE;
    endfunction

    assign sck_rise  = st.sck_s2 && !st.sck_s3;
    assign sck_fall  = !st.sck_s2 && st.sck_s3;
    assign cs_fall   = !st.cs_s2 && st.cs_s3;
    assign cs_rise   = st.cs_s2 && !st.cs_s3;
    assign byte_done = !st.cs_s2 && sck_rise && st.bit_cnt == 3'h7;
    assign rx_byte   = {st.shift_in[6:0], st.mosi_s2};

    // byte returned for the current read position
    always_comb begin
        fetch_src = 8'h00;
        if (st.cmd[7:5] == `RSCD_CMD_RD_REG) begin
            if (st.data_idx < 6'(reg_width)) begin
                fetch_src = reg_rd_data;
                if (st.reg_addr == `RSCD_BANK_REG && st.reg_byte_sel == 3'h0)
                    fetch_src[`RSCD_BANK_BIT] = st.bank;
            end
        end else if (st.cmd == `RSCD_CMD_RX_READ) begin
            fetch_src = rx_rd_data;
        end else if (st.cmd == `RSCD_CMD_WIDTH_RD) begin
            fetch_src = st.features_on ? rx_top_width : 8'h00;
        end
    end

    always_comb begin
        next_st = st;
        next_st.reg_rd_req = 1'b0;
        next_st.reg_wr_en  = 1'b0;
        next_st.tx_wr_en   = 1'b0;
        next_st.tx_commit  = 1'b0;
        next_st.rx_rd_req  = 1'b0;
        next_st.rx_pop     = 1'b0;
        next_st.flush_tx   = 1'b0;
        next_st.flush_rx   = 1'b0;
        next_st.pend       = 1'b0;
        next_st.fetch      = 1'b0;
        next_st.sck_s1  = sck;
        next_st.sck_s2  = st.sck_s1;
        next_st.sck_s3  = st.sck_s2;
        next_st.mosi_s1 = mosi;
        next_st.mosi_s2 = st.mosi_s1;
        next_st.cs_s1   = chip_select_n;
        next_st.cs_s2   = st.cs_s1;
        next_st.cs_s3   = st.cs_s2;

        // read pipeline: issue request, then capture the answer
        if (st.pend && st.phase == RSCD_DATA) begin
            next_st.data_idx = st.byte_cnt;
            next_st.fetch    = 1'b1;
            if (st.cmd[7:5] == `RSCD_CMD_RD_REG) begin
                next_st.reg_byte_sel = byte_sel(st.reg_addr, st.byte_cnt,
                                                reg_width, st.bank);
                next_st.reg_rd_req = st.byte_cnt < 6'(reg_width) &&
                                     st.byte_cnt < 6'(REG_MAX);
            end else if (st.cmd == `RSCD_CMD_RX_READ &&
                         st.byte_cnt < 6'(PAYLOAD_MAX)) begin
                next_st.rx_rd_req = 1'b1;
                next_st.read_rx   = 1'b1;
            end
        end
        if (st.fetch)
            next_st.next_byte = fetch_src;

        if (cs_fall) begin
            next_st.phase     = RSCD_CMD;
            next_st.bit_cnt   = 3'h0;
            next_st.byte_cnt  = 6'h00;
            next_st.shift_out = status_in;
            next_st.miso      = status_in[7];
            next_st.miso_oe   = 1'b1;
            next_st.wrote     = 1'b0;
            next_st.read_rx   = 1'b0;
        end else if (cs_rise) begin
            next_st.phase     = RSCD_IDLE;
            next_st.miso      = 1'b0;
            next_st.miso_oe   = 1'b0;
            next_st.tx_commit = st.wrote;
            next_st.rx_pop    = st.read_rx;
        end else if (!st.cs_s2) begin
            if (sck_rise) begin
                next_st.shift_in = rx_byte;
                next_st.bit_cnt  = 3'(st.bit_cnt + 3'h1);
            end
            if (byte_done && st.phase == RSCD_CMD) begin
                next_st.cmd       = rx_byte;
                next_st.phase     = RSCD_DATA;
                next_st.byte_cnt  = 6'h00;
                next_st.next_byte = 8'h00;
                next_st.reg_addr  = rx_byte[4:0];
                case (rx_byte)
                    `RSCD_CMD_FLUSH_TX: begin
                        next_st.flush_tx = 1'b1;
                        next_st.tx_reuse = 1'b0;
                    end
                    `RSCD_CMD_FLUSH_RX: next_st.flush_rx = 1'b1;
                    `RSCD_CMD_REPEAT:   next_st.tx_reuse = 1'b1;
                    `RSCD_CMD_TX_WRITE: next_st.tx_reuse = 1'b0;
                    `RSCD_CMD_UNACKED:
                        if (!st.features_on)
                            next_st.phase = RSCD_DEAD;
                    `RSCD_CMD_RX_READ, `RSCD_CMD_WIDTH_RD,
                    `RSCD_CMD_ACTIVATE, `RSCD_CMD_NOP: ;
                    default: begin
                        if (rx_byte[7:3] == `RSCD_CMD_ACK_WRITE) begin
                            if (!st.features_on || !prim_rx ||
                                rx_byte[2:0] > `RSCD_PIPE_MAX ||
                                ack_queue_full)
                                next_st.phase = RSCD_DEAD;
                        end else if (rx_byte[7:6] != 2'b00) begin
                            next_st.phase = RSCD_DEAD;
                        end
                    end
                endcase
                next_st.pend = 1'b1;
            end else if (byte_done && st.phase == RSCD_DATA) begin
                next_st.wr_data  = rx_byte;
                next_st.data_idx = st.byte_cnt;
                if (st.cmd[7:5] == `RSCD_CMD_WR_REG) begin
                    next_st.reg_byte_sel = byte_sel(st.reg_addr, st.byte_cnt,
                                                    reg_width, st.bank);
                    next_st.reg_wr_en = write_ok &&
                        st.byte_cnt < 6'(reg_width) &&
                        st.byte_cnt < 6'(REG_MAX);
                end else if (is_payload_write(st.cmd) &&
                             st.byte_cnt < 6'(PAYLOAD_MAX)) begin
                    next_st.tx_wr_en    = 1'b1;
                    next_st.tx_wr_noack = st.cmd == `RSCD_CMD_UNACKED;
                    next_st.tx_wr_ack   = st.cmd[3];
                    next_st.tx_wr_pipe  = st.cmd[2:0];
                    next_st.wrote       = 1'b1;
                end else if (st.cmd == `RSCD_CMD_ACTIVATE &&
                             st.byte_cnt == 6'h00 && write_ok) begin
                    if (rx_byte == `RSCD_ACT_FEATURES)
                        next_st.features_on = !st.features_on;
                    else if (rx_byte == `RSCD_ACT_BANK)
                        next_st.bank = !st.bank;
                end
                if (st.byte_cnt < 6'(PAYLOAD_MAX))
                    next_st.byte_cnt = 6'(st.byte_cnt + 6'h01);
                next_st.next_byte = 8'h00;
                next_st.pend      = 1'b1;
            end
            if (sck_fall) begin
                if (st.bit_cnt == 3'h0) begin
                    next_st.shift_out = st.next_byte;
                    next_st.miso      = st.next_byte[7];
                end else begin
                    next_st.shift_out = {st.shift_out[6:0], 1'b0};
                    next_st.miso      = st.shift_out[6];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.sck_s1 <= 1'b0;
            st.cs_s1 <= 1'b1;
            st.cs_s2 <= 1'b1;
            st.cs_s3 <= 1'b1;
            st.phase <= RSCD_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign miso         = st.miso;
    assign miso_oe      = st.miso_oe;
    assign reg_addr     = st.reg_addr;
    assign reg_byte_sel = st.reg_byte_sel;
    assign reg_rd_req   = st.reg_rd_req;
    assign reg_wr_en    = st.reg_wr_en;
    assign wr_data      = st.wr_data;
    assign data_idx     = st.data_idx;
    assign tx_wr_en     = st.tx_wr_en;
    assign tx_wr_noack  = st.tx_wr_noack;
    assign tx_wr_ack    = st.tx_wr_ack;
    assign tx_wr_pipe   = st.tx_wr_pipe;
    assign tx_commit    = st.tx_commit;
    assign rx_rd_req    = st.rx_rd_req;
    assign rx_pop       = st.rx_pop;
    assign flush_tx     = st.flush_tx;
    assign flush_rx     = st.flush_rx;
    assign tx_reuse     = st.tx_reuse;
    assign features_on  = st.features_on;
    assign bank         = st.bank;

    sequence s_frame_start;
        cs_fall;
    endsequence
    sequence s_cmd_byte(logic [7:0] code);
        byte_done && st.phase == RSCD_CMD && rx_byte == code;
    endsequence

    property p_oe_on_start;
        @(posedge clock) disable iff (!rst_n)
        s_frame_start |=> miso_oe;
    endproperty
    a_oe_on_start: assert property (p_oe_on_start)
        else $error("output not enabled at frame start");

    property p_status_first;
        @(posedge clock) disable iff (!rst_n)
        s_frame_start |=> miso == $past(status_in[7]);
    endproperty
    a_status_first: assert property (p_status_first)
        else $error("status bit 7 not first on the output");

    property p_repeat_set;
        @(posedge clock) disable iff (!rst_n)
        s_cmd_byte(`RSCD_CMD_REPEAT) |=> tx_reuse [*2];
    endproperty
    a_repeat_set: assert property (p_repeat_set)
        else $error("repeat flag not set by repeat command");

    property p_write_clears_repeat;
        @(posedge clock) disable iff (!rst_n)
        tx_wr_en && !tx_wr_ack && !tx_wr_noack |-> !tx_reuse;
    endproperty
    a_write_clears_repeat: assert property (p_write_clears_repeat)
        else $error("repeat flag still set during payload write");

    property p_flush_tx;
        @(posedge clock) disable iff (!rst_n)
        s_cmd_byte(`RSCD_CMD_FLUSH_TX) |=> flush_tx && !tx_reuse ##1 !flush_tx;
    endproperty
    a_flush_tx: assert property (p_flush_tx)
        else $error("transmit flush not a single pulse");

    property p_unacked_gated;
        @(posedge clock) disable iff (!rst_n)
        tx_wr_en && tx_wr_noack |-> features_on;
    endproperty
    a_unacked_gated: assert property (p_unacked_gated)
        else $error("unacked write while features inactive");

    property p_ack_pipe;
        @(posedge clock) disable iff (!rst_n)
        tx_wr_en && tx_wr_ack |-> tx_wr_pipe <= `RSCD_PIPE_MAX && features_on;
    endproperty
    a_ack_pipe: assert property (p_ack_pipe)
        else $error("ack payload with bad pipe or inactive features");

    property p_write_mode;
        @(posedge clock) disable iff (!rst_n)
        reg_wr_en |-> $past(write_ok);
    endproperty
    a_write_mode: assert property (p_write_mode)
        else $error("register write outside power-down or standby");

    property p_payload_limit;
        @(posedge clock) disable iff (!rst_n)
        tx_wr_en |-> data_idx < 6'(PAYLOAD_MAX);
    endproperty
    a_payload_limit: assert property (p_payload_limit)
        else $error("payload byte beyond the limit");

    property p_bank_toggle;
        @(posedge clock) disable iff (!rst_n)
        byte_done && st.phase == RSCD_DATA && st.cmd == `RSCD_CMD_ACTIVATE &&
        st.byte_cnt == 6'h00 && write_ok && rx_byte == `RSCD_ACT_BANK
        |=> bank != $past(bank);
    endproperty
    a_bank_toggle: assert property (p_bank_toggle)
        else $error("bank did not toggle");

    property p_pop_at_end;
        @(posedge clock) disable iff (!rst_n)
        rx_pop |-> $past(cs_rise) && !miso_oe;
    endproperty
    a_pop_at_end: assert property (p_pop_at_end)
        else $error("receive entry popped outside frame end");
endmodule // rscd_top

// [tb/rscd_host.sv]
// host serial master model driving the command decoder pins
`timescale 1ns/1ps
module rscd_host (
    // bench clock
    input  wire logic clock,
    // serial pins
    output logic      chip_select_n,
    output logic      sck,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        chip_select_n = 1'b1;
        sck           = 1'b0;
        mosi          = 1'b0;
    end

    // mode 0, 125 ns sck: 13 clocks low, 12 high; sck idle low
    task automatic frame(input int n, input logic [47:0] tx,
                         output logic [47:0] rx);
        rx = 48'h0;
        @(negedge clock);
        chip_select_n = 1'b0;
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                mosi = tx[8*b+i];
                repeat (13) @(negedge clock);
                rx[8*b+i] = miso;
                sck = 1'b1;
                repeat (12) @(negedge clock);
                sck = 1'b0;
            end
        end
        repeat (13) @(negedge clock);
        chip_select_n = 1'b1;
        // released line: no pull, so show the inverse of the last bit
        mosi = ~mosi;
        repeat (10) @(negedge clock);
    endtask
endmodule // rscd_host

// [tb/rscd_top_tb_top.sv]
// self-checking bench of the serial command decoder
`timescale 1ns/1ps
module rscd_top_tb_top;
    logic clock, rst_n, chip_select_n, sck, mosi, miso, miso_oe;
    logic [7:0] status_in, reg_rd_data, wr_data, rx_rd_data;
    logic write_ok, prim_rx, ack_queue_full;
    logic [4:0] reg_addr;
    logic [2:0] reg_byte_sel, reg_width, tx_wr_pipe;
    logic reg_rd_req, reg_wr_en, tx_wr_en, tx_wr_noack, tx_wr_ack;
    logic [5:0] data_idx;
    logic tx_commit, rx_rd_req, rx_pop, flush_tx, flush_rx;
    logic tx_reuse, features_on, bank;
    logic [47:0] rx;
    logic [15:0] wr_log [8];
    logic [18:0] tx_log [8];
    int n_wr, n_tx, n_ftx, n_frx, n_cm, n_pop, n_oe;
    int n_mismatch = 0;
    int checks = 0;

    rscd_top i_rscd_top (.clock(clock), .rst_n(rst_n),
        .chip_select_n(chip_select_n), .sck(sck), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .status_in(status_in),
        .write_ok(write_ok), .prim_rx(prim_rx),
        .ack_queue_full(ack_queue_full), .reg_addr(reg_addr),
        .reg_byte_sel(reg_byte_sel), .reg_width(reg_width),
        .reg_rd_req(reg_rd_req), .reg_rd_data(reg_rd_data),
        .reg_wr_en(reg_wr_en), .wr_data(wr_data), .data_idx(data_idx),
        .tx_wr_en(tx_wr_en), .tx_wr_noack(tx_wr_noack),
        .tx_wr_ack(tx_wr_ack), .tx_wr_pipe(tx_wr_pipe),
        .tx_commit(tx_commit), .rx_rd_req(rx_rd_req),
        .rx_rd_data(rx_rd_data), .rx_top_width(8'h1C), .rx_pop(rx_pop),
        .flush_tx(flush_tx), .flush_rx(flush_rx), .tx_reuse(tx_reuse),
        .features_on(features_on), .bank(bank));

    rscd_host i_rscd_host (.clock(clock), .chip_select_n(chip_select_n),
        .sck(sck), .mosi(mosi), .miso(miso));

    // register file: odd addresses 2 bytes, even 3, address 7 one byte
    assign reg_width = (reg_addr == 5'h07) ? 3'h1 :
                       (reg_addr[0] ? 3'h2 : 3'h3);

    function automatic logic [7:0] rv(logic [4:0] a, logic [2:0] l);
        return {1'b0, a[3:0], l};
    endfunction

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // far side of the register file and queues, plus event logging
    always @(negedge clock) begin
        if (reg_rd_req === 1'b1)
            reg_rd_data <= rv(reg_addr, reg_byte_sel);
        if (rx_rd_req === 1'b1)
            rx_rd_data <= {2'h3, data_idx};
        if (reg_wr_en === 1'b1) begin
            wr_log[n_wr[2:0]] = {reg_addr, reg_byte_sel, wr_data};
            n_wr++;
        end
        if (tx_wr_en === 1'b1) begin
            tx_log[n_tx[2:0]] = {tx_wr_noack, tx_wr_ack, tx_wr_pipe,
                                 data_idx, wr_data};
            n_tx++;
        end
        n_ftx += int'(flush_tx === 1'b1);
        n_frx += int'(flush_rx === 1'b1);
        n_cm  += int'(tx_commit === 1'b1);
        n_pop += int'(rx_pop === 1'b1);
        n_oe  += int'(miso_oe === 1'b1);
    end

    task automatic chk(input string name, input logic [47:0] e,
                       input logic [47:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h, seen %0h", name, e, g);
        end
    endtask

    function automatic int ev();
        return n_wr + n_tx + n_ftx + n_frx + n_cm + n_pop;
    endfunction

    task automatic cmd(input int n, input logic [47:0] tx);
        n_wr = 0;
        n_tx = 0;
        n_ftx = 0;
        n_frx = 0;
        n_cm = 0;
        n_pop = 0;
        n_oe = 0;
        i_rscd_host.frame(n, tx, rx);
        chk("status", {40'h0, status_in}, {40'h0, rx[7:0]});
        chk("oe in frame", 1, n_oe != 0);
        chk("oe after frame", 0, miso_oe);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // about 13k clocks of traffic expected; generous margin
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        status_in = 8'h0E;
        write_ok = 1'b1;
        prim_rx = 1'b0;
        ack_queue_full = 1'b0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        cmd(1, 48'hFF);
        chk("nop events", 0, ev());
        status_in = 8'h5A;
        cmd(3, 48'hFFFF05);
        chk("b0 lane0", rv(5, 0), rx[15:8]);
        chk("b0 lane1", rv(5, 1), rx[23:16]);
        cmd(2, 48'h5350);
        chk("bank", 1, bank);
        cmd(4, 48'hFFFFFF02);
        for (int b = 0; b < 3; b++)
            chk("b1 lo", rv(2, 3'(2 - b)), rx[8*b+8+:8]);
        cmd(3, 48'h424122);
        chk("b1 wr count", 2, n_wr);
        chk("b1 wr0", {5'h02, 3'h2, 8'h41}, wr_log[0]);
        chk("b1 wr1", {5'h02, 3'h1, 8'h42}, wr_log[1]);
        cmd(2, 48'hFF07);
        chk("bank bit", 8'hB8, rx[15:8]);
        cmd(3, 48'hFFFF09);
        chk("b1 hi", {rv(9, 1), rv(9, 0)}, rx[23:8]);
        cmd(2, 48'h5350);
        chk("bank back", 0, bank);
        cmd(4, 48'h33323123);
        chk("wr count", 2, n_wr);
        chk("wr0", {5'h03, 3'h0, 8'h31}, wr_log[0]);
        chk("wr1", {5'h03, 3'h1, 8'h32}, wr_log[1]);
        write_ok = 1'b0;
        cmd(2, 48'h4423);
        chk("wr refused", 0, n_wr);
        cmd(2, 48'h7350);
        chk("act refused", 0, features_on);
        write_ok = 1'b1;
        cmd(1, 48'hE3);
        chk("reuse set", 1, tx_reuse);
        cmd(4, 48'h0C0B0AA0);
        chk("tx count", 3, n_tx);
        for (int b = 0; b < 3; b++)
            chk("tx byte", {5'h0, 6'(b), 8'(8'h0A + b)}, tx_log[b]);
        chk("commit", 1, n_cm);
        chk("reuse off wr", 0, tx_reuse);
        cmd(1, 48'hE3);
        cmd(1, 48'hE1);
        chk("flush tx", 1, n_ftx);
        chk("reuse off fl", 0, tx_reuse);
        cmd(1, 48'hE2);
        chk("flush rx", 1, n_frx);
        cmd(3, 48'hFFFF61);
        chk("rx bytes", 16'hC1C0, rx[23:8]);
        chk("rx pop", 1, n_pop);
        cmd(2, 48'hFF60);
        chk("width off", 0, rx[15:8]);
        cmd(3, 48'h0201B0);
        chk("noack off", 0, n_tx);
        cmd(2, 48'h7350);
        chk("features", 1, features_on);
        cmd(2, 48'hFF60);
        chk("width", 8'h1C, rx[15:8]);
        cmd(3, 48'h0201B0);
        chk("noack n", 2, n_tx);
        chk("noack", {5'h10, 6'h1, 8'h02}, tx_log[1]);
        prim_rx = 1'b1;
        cmd(2, 48'h07AB);
        chk("ack", {5'h0B, 6'h0, 8'h07}, tx_log[0]);
        cmd(2, 48'h07AE);
        chk("bad pipe", 0, n_tx);
        ack_queue_full = 1'b1;
        cmd(2, 48'h07AB);
        chk("ack full", 0, n_tx);
        ack_queue_full = 1'b0;
        prim_rx = 1'b0;
        cmd(3, 48'hE1A080);
        chk("unknown ev", 0, ev());
        chk("unknown out", 0, rx[23:8]);
        cmd(2, 48'h7350);
        chk("features off", 0, features_on);
        print_verdict();
    end
endmodule // rscd_top_tb_top
